// ---- logic/lsr_cfg.svh ----
// lsr_cfg.svh: port numbers, field positions and sequence lengths
// assumes 8-bit legacy i/o space decoded by the caller
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_PORT_DMA_LO_STAT 8'h08
`define LSR_PORT_PIC_M 8'h20
`define LSR_PORT_PIC_S 8'ha0
`define LSR_PORT_DMA_HI 8'hd0
`define LSR_PORT_MODE 8'hf0
`define LSR_PORT_WSEL 8'hf1
`define LSR_PORT_SHDW 8'hf2
`define LSR_PIC_READS 4'hc
`define LSR_DMA_READS 3'h6
`define LSR_CMD_MASK 8'hd4
`define LSR_PIC_INIT_WORD_2_MASK 8'hf8
`define LSR_PIC_INIT_WORD_4_MASK 8'h12
`define LSR_PIC_OPERATION_WORD_2_MASK 8'he7
`define LSR_WSEL_PIC_INIT_WORD_2 3'h0
`define LSR_WSEL_PIC_INIT_WORD_3 3'h1
`define LSR_WSEL_PIC_INIT_WORD_4 3'h2
`define LSR_WSEL_PIC_INTERRUPT_MASK_WORD 3'h3
`define LSR_WSEL_PIC_OPERATION_WORD_2 3'h4
`define LSR_WSEL_PIC_OPERATION_WORD_3 3'h5
`define LSR_WSEL_CUR_ADDR 3'h6
`define LSR_WSEL_CUR_CNT 3'h7
`define LSR_WSEL_BASE_ADDR 4'h8
`define LSR_WSEL_BASE_CNT 4'h9
`define LSR_WSEL_DMA_CMD 4'ha
`define LSR_WSEL_DMA_REQ 4'hb
`define LSR_WSEL_DMA_MODE 4'hc
`endif

// ---- logic/lsr_pkg.sv ----
// lsr_pkg.sv: shared types for the shadow save/restore block
// assumes lsr_cfg.svh supplies the numeric constants
package lsr_pkg;
  typedef logic [7:0] lsr_byte_t;
  typedef logic [15:0] lsr_word_t;
endpackage

// ---- logic/lsr_shadow.sv ----
// lsr_shadow.sv: shadow save/restore access for legacy pic and dma registers
// assumes a single-cycle i/o port, strobes never together, data one cycle after read
// What this block does, and what software must do (RULE5, RULE10)
// RULE1: in save/restore mode, reads of a port step through its registers in order
// RULE2: port 20h returns master then slave init words 2-4 and operation words 1-3
// RULE3: port d0h returns command, request, then channel 4-7 modes tagged 00..11
// RULE4: dma command readback forces bits 5, 3, 1 and 0 to zero
// RULE5: software reads interrupt mask words before entering the mode
// RULE6: init word 2 bits 2:0, word 4 bits 7:5, 3:2 and 0 read zero
// RULE7: operation word 2 bits 4:3 zero; word 3 bit7 0, 4:3 01, bit5 copies bit6
// RULE8: in mode, writes to 08h and d0h load the dma status registers
// RULE9: in normal mode base address/count writes also load current address/count
// RULE10: software restores base first, enters the mode, then writes current values
// RULE11: in mode, current address/count accept writes and leave base untouched
// RULE12: each sequence pointer restarts on mode entry and wraps after its last entry
//
// The plain strobed port and the address map are this design's own decisions.
`include "lsr_cfg.svh"
module lsr_shadow #(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire lsr_pkg::lsr_byte_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output lsr_pkg::lsr_byte_t RDATA_O,
  // state
  output logic MODE_O
);
  import lsr_pkg::*;

  if (NUM_CH != 8) begin : g_bad_num_ch
    $error("lsr_shadow serves exactly 8 dma channels");
  end

  // pic[0]=master, pic[1]=slave; entries follow the data port select codes 0..5
  lsr_byte_t pic_q [2][6];
  lsr_word_t base_addr_q [NUM_CH];
  lsr_word_t base_cnt_q [NUM_CH];
  lsr_word_t cur_addr_q [NUM_CH];
  lsr_word_t cur_cnt_q [NUM_CH];
  lsr_byte_t dma_cmd_q [2];
  lsr_byte_t dma_req_q [2];
  lsr_byte_t dma_mode_q [NUM_CH];
  lsr_byte_t dma_stat_q [2];
  logic mode_q;
  logic [3:0] wsel_q;
  logic [2:0] wch_q;
  logic wbyte_q;
  logic [3:0] pic_ptr_q;
  logic [2:0] dma_ptr_q;
  lsr_byte_t rdata_q;
  lsr_byte_t wr_data;
  logic pic_sel;
  logic [2:0] pic_idx;
  lsr_byte_t pic_rd;
  lsr_byte_t dma_rd;
  logic mode_entry;

  assign wr_data = WDATA_I;
  assign mode_entry = WR_I && ADDR_I == `LSR_PORT_MODE && wr_data[0] && !mode_q;

  // mode control; mode register bit 0, write-select port picks target and channel
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      mode_q <= 1'b0;
      wsel_q <= 4'h0;
      wch_q <= 3'h0;
    end else if (WR_I && ADDR_I == `LSR_PORT_MODE) begin
      mode_q <= wr_data[0];
    end else if (WR_I && ADDR_I == `LSR_PORT_WSEL) begin
      wsel_q <= wr_data[3:0];
      wch_q <= wr_data[6:4];
    end
  end

  // readback pointers
  // only a 0->1 mode write restarts; rewriting 1 keeps a save walk going
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || mode_entry) begin
      pic_ptr_q <= 4'h0; // RULE12
      dma_ptr_q <= 3'h0; // RULE12
    end else if (RD_I && mode_q) begin
      if (ADDR_I == `LSR_PORT_PIC_M) begin
        pic_ptr_q <= (pic_ptr_q == `LSR_PIC_READS - 4'h1) ? 4'h0 : pic_ptr_q + 4'h1; // RULE1 RULE12
      end
      if (ADDR_I == `LSR_PORT_DMA_HI) begin
        dma_ptr_q <= (dma_ptr_q == `LSR_DMA_READS - 3'h1) ? 3'h0 : dma_ptr_q + 3'h1; // RULE1 RULE12
      end
    end
  end

  // byte flip-flop for 16-bit loads through the shadow data port
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      wbyte_q <= 1'b0;
    end else if (WR_I && ADDR_I == `LSR_PORT_WSEL) begin
      wbyte_q <= 1'b0;
    end else if (WR_I && ADDR_I == `LSR_PORT_SHDW && wsel_q >= {1'b0, `LSR_WSEL_CUR_ADDR}
                 && wsel_q <= `LSR_WSEL_BASE_CNT) begin
      wbyte_q <= ~wbyte_q;
    end
  end

  // pic shadow copies, loaded by the controller side through the data port
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pic_q <= '{default: 8'h00};
    end else if (WR_I && ADDR_I == `LSR_PORT_SHDW && wsel_q <= {1'b0, `LSR_WSEL_PIC_OPERATION_WORD_3}) begin
      pic_q[wch_q[0]][wsel_q[2:0]] <= wr_data;
    end
  end

  // dma base registers; refused in the mode so a restore cannot clobber the saved base
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      base_addr_q <= '{default: 16'h0000};
      base_cnt_q <= '{default: 16'h0000};
    end else if (WR_I && ADDR_I == `LSR_PORT_SHDW && !mode_q) begin // RULE11
      if (wsel_q == `LSR_WSEL_BASE_ADDR) begin
        base_addr_q[wch_q][wbyte_q*8 +: 8] <= wr_data;
      end
      if (wsel_q == `LSR_WSEL_BASE_CNT) begin
        base_cnt_q[wch_q][wbyte_q*8 +: 8] <= wr_data;
      end
    end
  end

  // dma current registers: follow base writes in normal mode, own writes in the mode
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      cur_addr_q <= '{default: 16'h0000};
      cur_cnt_q <= '{default: 16'h0000};
    end else if (WR_I && ADDR_I == `LSR_PORT_SHDW) begin
      if (wsel_q == `LSR_WSEL_BASE_ADDR && !mode_q) begin
        cur_addr_q[wch_q][wbyte_q*8 +: 8] <= wr_data; // RULE9
      end
      if (wsel_q == `LSR_WSEL_BASE_CNT && !mode_q) begin
        cur_cnt_q[wch_q][wbyte_q*8 +: 8] <= wr_data; // RULE9
      end
      if (wsel_q == {1'b0, `LSR_WSEL_CUR_ADDR} && mode_q) begin
        cur_addr_q[wch_q][wbyte_q*8 +: 8] <= wr_data; // RULE11
      end
      if (wsel_q == {1'b0, `LSR_WSEL_CUR_CNT} && mode_q) begin
        cur_cnt_q[wch_q][wbyte_q*8 +: 8] <= wr_data; // RULE11
      end
    end
  end

  // dma status, writable only in the mode; normal writes there belong to other registers
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      dma_stat_q <= '{default: 8'h00};
    end else if (WR_I && mode_q) begin
      if (ADDR_I == `LSR_PORT_DMA_LO_STAT) begin
        dma_stat_q[0] <= wr_data; // RULE8
      end
      if (ADDR_I == `LSR_PORT_DMA_HI) begin
        dma_stat_q[1] <= wr_data; // RULE8
      end
    end
  end

  // dma command, request and mode, loaded through the data port
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      dma_cmd_q <= '{default: 8'h00};
      dma_req_q <= '{default: 8'h00};
      dma_mode_q <= '{default: 8'h00};
    end else if (WR_I && ADDR_I == `LSR_PORT_SHDW) begin
      if (wsel_q == `LSR_WSEL_DMA_CMD) dma_cmd_q[wch_q[2]] <= wr_data;
      if (wsel_q == `LSR_WSEL_DMA_REQ) dma_req_q[wch_q[2]] <= wr_data;
      if (wsel_q == `LSR_WSEL_DMA_MODE) dma_mode_q[wch_q] <= wr_data;
    end
  end

  // pic readback with reserved bits forced
  always_comb begin
    pic_sel = (pic_ptr_q >= 4'h6); // RULE2
    pic_idx = pic_sel ? 3'(pic_ptr_q - 4'h6) : pic_ptr_q[2:0];
    pic_rd = pic_q[pic_sel][pic_idx];
    case (pic_idx)
      3'h0: pic_rd = pic_rd & `LSR_PIC_INIT_WORD_2_MASK; // RULE6
      3'h2: pic_rd = pic_rd & `LSR_PIC_INIT_WORD_4_MASK; // RULE6
      3'h4: pic_rd = pic_rd & `LSR_PIC_OPERATION_WORD_2_MASK; // RULE7
      3'h5: pic_rd = {1'b0, pic_rd[6], pic_rd[6], 2'b01, pic_rd[2:0]}; // RULE7
      default: pic_rd = pic_rd;
    endcase
  end

  // dma 4-7 readback sequence
  always_comb begin
    case (dma_ptr_q)
      3'h0: dma_rd = dma_cmd_q[1] & `LSR_CMD_MASK; // RULE3 RULE4
      3'h1: dma_rd = dma_req_q[1]; // RULE3
      3'h2: dma_rd = {dma_mode_q[4][7:2], 2'b00}; // RULE3
      3'h3: dma_rd = {dma_mode_q[5][7:2], 2'b01}; // RULE3
      3'h4: dma_rd = {dma_mode_q[6][7:2], 2'b10}; // RULE3
      3'h5: dma_rd = {dma_mode_q[7][7:2], 2'b11}; // RULE3
      default: dma_rd = 8'h00;
    endcase
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || !RD_I) begin
      rdata_q <= 8'h00;
    end else begin
      case (ADDR_I)
        `LSR_PORT_MODE: rdata_q <= {7'h00, mode_q};
        `LSR_PORT_WSEL: rdata_q <= {1'b0, wch_q, wsel_q};
        `LSR_PORT_PIC_M: rdata_q <= mode_q ? pic_rd : 8'h00; // RULE1 RULE2
        `LSR_PORT_DMA_HI: rdata_q <= mode_q ? dma_rd : dma_stat_q[1]; // RULE1 RULE3
        `LSR_PORT_DMA_LO_STAT: rdata_q <= dma_stat_q[0];
        `LSR_PORT_SHDW: rdata_q <= wsel_q[0] ? cur_cnt_q[wch_q][7:0] : cur_addr_q[wch_q][7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign RDATA_O = rdata_q;
  assign MODE_O = mode_q;
endmodule // lsr_shadow

// ---- sim/lsr_shadow_chk.sv ----
// lsr_shadow_chk.sv: port assertions for lsr_shadow
// assumes one clock, sync reset; bound below
module lsr_shadow_chk (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire lsr_pkg::lsr_byte_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire lsr_pkg::lsr_byte_t RDATA_O,
  input wire logic MODE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import lsr_pkg::*;
  logic [3:0] pp_q;
  logic [2:0] dp_q;
  wire prd = RD_I && MODE_O && ADDR_I == 8'h20;
  wire drd = RD_I && MODE_O && ADDR_I == 8'hd0;
  wire ent = WR_I && ADDR_I == 8'hf0 && WDATA_I[0] && !MODE_O;
  // own pointers, so a design pointer that never restarts shows
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || ent) pp_q <= 4'h0;
    else if (prd) pp_q <= (pp_q == 4'hb) ? 4'h0 : pp_q + 4'h1;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || ent) dp_q <= 3'h0;
    else if (drd) dp_q <= (dp_q == 3'h5) ? 3'h0 : dp_q + 3'h1;
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);
  chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("stray read data");
  chk_mode_write: assert property (WR_I && ADDR_I == 8'hf0 |=> MODE_O == $past(WDATA_I[0]))
    else $error("mode flag wrong");
  chk_init2_zero: assert property (prd && pp_q % 6 == 0 |=> RDATA_O[2:0] == 3'h0)
    else $error("init word 2 bits");
  chk_init4_zero: assert property (prd && pp_q % 6 == 2 |=> (RDATA_O & 8'hed) == 8'h00)
    else $error("init word 4 bits");
  chk_oper2_zero: assert property (prd && pp_q % 6 == 4 |=> RDATA_O[4:3] == 2'h0)
    else $error("op word 2 bits");
  chk_oper3_fixed: assert property (prd && pp_q % 6 == 5 |=>
    !RDATA_O[7] && RDATA_O[4:3] == 2'h1 && RDATA_O[5] == RDATA_O[6]) else $error("op word 3 bits");
  chk_cmd_zero: assert property (drd && dp_q == 3'h0 |=> (RDATA_O & 8'h2b) == 8'h00)
    else $error("command bits");
  chk_mode_tag: assert property (drd && dp_q > 3'h1 |=> RDATA_O[1:0] == $past(dp_q[1:0]) - 2'h2)
    else $error("channel tag");
  cover property (prd && pp_q == 4'hb);
  cover property (drd && dp_q == 3'h5);
  cover property (WR_I && ADDR_I == 8'h08 && MODE_O);
endmodule // lsr_shadow_chk
bind lsr_shadow lsr_shadow_chk i_lsr_shadow_chk (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MODE_O(MODE_O));

// ---- sim/lsr_shadow_tb_top.sv ----
// lsr_shadow_tb_top.sv: self-checking bench for lsr_shadow
// assumes package, header and checker compiled first
module lsr_shadow_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lsr_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, mode;
  lsr_byte_t addr = 0, wd = 0, rdat, b, pv [12], dv [6];
  int failures = 0, checks = 0, cyc = 0, seed = 57;
  always #5 clk = ~clk;
  lsr_shadow i_lsr_shadow (.CLK_SYS_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .MODE_O(mode));
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // strobe stays up until the next op; every write run ends in a read
  task automatic op(input logic w, input lsr_byte_t a, d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
  endtask
  task automatic check(input lsr_byte_t seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic get(input lsr_byte_t a, e);
    op(1'b0, a, 8'h00);
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdat, e);
  endtask
  function automatic lsr_byte_t pic_exp(input int i, input lsr_byte_t v);
    case (i % 6)
      0: return v & 8'hf8;
      2: return v & 8'h12;
      4: return v & 8'he7;
      5: return {1'b0, v[6], v[6], 2'b01, v[2:0]};
      default: return v;
    endcase
  endfunction
  function automatic lsr_byte_t dma_exp(input int i, input lsr_byte_t v);
    return i == 0 ? v & 8'hd4 : i == 1 ? v : {v[7:2], 2'(i - 2)};
  endfunction
  initial begin
    foreach (pv[i]) pv[i] = 8'($random(seed));
    foreach (dv[i]) dv[i] = 8'($random(seed));
    b = 8'($random(seed));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      op(1'b1, 8'hf1, 8'((i / 6) * 16 + i % 6));
      op(1'b1, 8'hf2, pv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      op(1'b1, 8'hf1, i < 2 ? 8'h4a + 8'(i) : 8'h2c + 8'(i * 16));
      op(1'b1, 8'hf2, dv[i]);
    end
    op(1'b1, 8'hf1, 8'h58);
    op(1'b1, 8'hf2, b);
    op(1'b1, 8'hf2, ~b);
    op(1'b1, 8'hf1, 8'h56);
    get(8'hf2, b);
    op(1'b1, 8'h08, ~b);
    get(8'h08, 8'h00);
    get(8'h20, 8'h00);
    op(1'b1, 8'hf0, 8'h01);
    for (int i = 0; i < 13; i++) get(8'h20, pic_exp(i, pv[i % 12]));
    check({7'h00, mode}, 8'h01);
    for (int i = 0; i < 7; i++) get(8'hd0, dma_exp(i % 6, dv[i % 6]));
    op(1'b1, 8'h08, b);
    get(8'h08, b);
    op(1'b1, 8'hd0, ~b);
    op(1'b1, 8'hf1, 8'h56);
    op(1'b1, 8'hf2, b ^ 8'h5a);
    op(1'b1, 8'hf2, b);
    op(1'b1, 8'hf1, 8'h56);
    get(8'hf2, b ^ 8'h5a);
    op(1'b1, 8'hf0, 8'h00);
    get(8'hd0, ~b);
    check({7'h00, mode}, 8'h00);
    op(1'b1, 8'hf0, 8'h01);
    get(8'h20, pic_exp(0, pv[0]));
    get(8'hd0, dma_exp(0, dv[0]));
    end_sim();
  end
  always @(posedge clk) begin
    if (++cyc > 2000) begin
      failures++;
      end_sim();
    end
  end
endmodule // lsr_shadow_tb_top
